// File: hdl/cbce_pkg.sv
// ****************************************************************
// block constants
// ****************************************************************
package cbce_pkg;

   localparam int CBCE_BYTE_W      = 8;
   localparam int CBCE_BLOCK_BYTES = 16;
   localparam int CBCE_SHORT_BYTES = 4;
   localparam int CBCE_ENT_BYTES   = 17;
   localparam int CBCE_FIFO_DEPTH  = 16;
   localparam int CBCE_FIFO_W      = 9;

   // ****************************************************************
   // host command codes
   // ****************************************************************
   localparam logic [3:0] CBCE_CMD_AUTH   = 4'h1;
   localparam logic [3:0] CBCE_CMD_READ   = 4'h2;
   localparam logic [3:0] CBCE_CMD_WRITE  = 4'h3;
   localparam logic [3:0] CBCE_CMD_VWRITE = 4'h4;
   localparam logic [3:0] CBCE_CMD_INC    = 4'h5;
   localparam logic [3:0] CBCE_CMD_DEC    = 4'h6;
   localparam logic [3:0] CBCE_CMD_COPY   = 4'h7;
   localparam logic [3:0] CBCE_CMD_COMB   = 4'h8;

   // ****************************************************************
   // parameter and flag bit positions
   // ****************************************************************
   localparam int CBCE_P2_LEN4_BIT  = 0;
   localparam int CBCE_P2_ENC_BIT   = 1;
   localparam int CBCE_P2_DIV_BIT   = 0;
   localparam int CBCE_CF_NEW_BIT   = 0;
   localparam int CBCE_CF_DIV_BIT   = 1;
   localparam int CBCE_CF_REUSE_BIT = 2;

   // ****************************************************************
   // entry lengths in bytes
   // ****************************************************************
   localparam logic [4:0] CBCE_NEED_READ  = 5'h01;
   localparam logic [4:0] CBCE_NEED_PAIR  = 5'h02;
   localparam logic [4:0] CBCE_NEED_KEY   = 5'h03;
   localparam logic [4:0] CBCE_NEED_W4    = 5'h05;
   localparam logic [4:0] CBCE_NEED_VALUE = 5'h06;
   localparam logic [4:0] CBCE_NEED_W16   = 5'h11;

   // ****************************************************************
   // status codes
   // ****************************************************************
   localparam logic [1:0] CBCE_ST_OK     = 2'h0;
   localparam logic [1:0] CBCE_ST_REJECT = 2'h1;
   localparam logic [1:0] CBCE_ST_CARD   = 2'h2;
   localparam logic [1:0] CBCE_ST_FORMAT = 2'h3;

   typedef enum logic [2:0] {
      CBCE_OP_AUTH,
      CBCE_OP_READ,
      CBCE_OP_WRITE16,
      CBCE_OP_WRITE4,
      CBCE_OP_INC,
      CBCE_OP_DEC,
      CBCE_OP_RESTORE,
      CBCE_OP_TRANSFER
   } cbce_card_op_t;

   typedef enum logic [2:0] {
      CBCE_S_IDLE,
      CBCE_S_FETCH,
      CBCE_S_ISSUE,
      CBCE_S_WAIT,
      CBCE_S_RESP,
      CBCE_S_DRAIN,
      CBCE_S_DONE
   } cbce_state_t;

endpackage

// File: hdl/cbce_fifo.sv
`timescale 1ns/1ps
// ****************************************************************
// data field fifo
// ****************************************************************
// pointers wrap by overflow, so depth must be a power of two
module cbce_fifo
   import cbce_pkg::*;
#(
   parameter int WIDTH = CBCE_FIFO_W,
   parameter int DEPTH = CBCE_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic             i_clock,
   input  wire logic             i_rst_n,
   // fill side
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_in_ready,
   // drain side
   output logic                  o_out_valid,
   output logic      [WIDTH-1:0] o_out_data,
   input  wire logic             i_out_ready
);

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr_ptr;
      logic [AW-1:0]               rd_ptr;
      logic [AW:0]                 count;
   } cbce_fifo_state_t;

   cbce_fifo_state_t r_reg;
   cbce_fifo_state_t r_next;
   logic             push;
   logic             pop;

   assign o_in_ready  = (r_reg.count != FULL_COUNT);
   assign o_out_valid = (r_reg.count != '0);
   assign o_out_data  = r_reg.mem[r_reg.rd_ptr];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   always_comb begin
      r_next = r_reg;
      if (push) begin
         r_next.mem[r_reg.wr_ptr] = i_in_data;
         r_next.wr_ptr            = r_reg.wr_ptr + 1'b1;
      end
      if (pop) begin
         r_next.rd_ptr = r_reg.rd_ptr + 1'b1;
      end
      unique case ({push, pop})
         2'b10:   r_next.count = r_reg.count + 1'b1;
         2'b01:   r_next.count = r_reg.count - 1'b1;
         default: r_next.count = r_reg.count;
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

endmodule // cbce_fifo

// File: hdl/cbce_engine.sv
`timescale 1ns/1ps
module cbce_engine
   import cbce_pkg::*;
(
   // clock and reset
   input  wire logic         i_clock,
   input  wire logic         i_rst_n,
   // host command
   input  wire logic         i_cmd_valid,
   input  wire logic [3:0]   i_cmd_code,
   input  wire logic [7:0]   i_cmd_p1,
   input  wire logic [7:0]   i_cmd_p2,
   output logic              o_cmd_ready,
   // host data field
   input  wire logic         i_data_valid,
   input  wire logic [7:0]   i_data_byte,
   input  wire logic         i_data_last,
   output logic              o_data_ready,
   // host block response
   output logic              o_rsp_valid,
   output logic      [127:0] o_rsp_block,
   input  wire logic         i_rsp_ready,
   // command status
   output logic              o_done,
   output logic      [1:0]   o_status,
   output logic              o_auth_state,
   // card operation port
   output logic              o_card_req,
   output logic      [2:0]   o_card_op,
   output logic      [7:0]   o_card_addr,
   output logic      [7:0]   o_card_arg,
   output logic              o_card_flag,
   output logic      [127:0] o_card_wdata,
   input  wire logic         i_card_ack,
   input  wire logic         i_card_ok,
   input  wire logic [127:0] i_card_rdata
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      cbce_state_t                     state;
      logic [3:0]                      cmd;
      logic [7:0]                      count;
      logic [7:0]                      p2;
      logic                            auth_done;
      logic [7:0]                      key_ref;
      logic [CBCE_ENT_BYTES-1:0][7:0]  ent;
      logic [4:0]                      idx;
      logic                            step;
      logic                            seen_last;
      cbce_card_op_t                   card_op;
      logic [7:0]                      card_addr;
      logic [7:0]                      card_arg;
      logic                            card_flag;
      logic [127:0]                    card_wdata;
      logic [127:0]                    rsp_block;
      logic [1:0]                      status;
   } cbce_eng_state_t;

   cbce_eng_state_t r_reg;
   cbce_eng_state_t r_next;
   logic            fifo_valid;
   logic [8:0]      fifo_data;
   logic            fifo_pop;
   logic            cmd_reject;

   // ****************************************************************
   // data field buffer
   // ****************************************************************
   // lets the host stream the data field ahead of slow card traffic
   cbce_fifo #(
      .WIDTH (CBCE_FIFO_W),
      .DEPTH (CBCE_FIFO_DEPTH)
   ) u_fifo (
      .i_clock     (i_clock),
      .i_rst_n     (i_rst_n),
      .i_in_valid  (i_data_valid),
      .i_in_data   ({i_data_last, i_data_byte}),
      .o_in_ready  (o_data_ready),
      .o_out_valid (fifo_valid),
      .o_out_data  (fifo_data),
      .i_out_ready (fifo_pop)
   );

   assign fifo_pop = (r_reg.state == CBCE_S_FETCH) || (r_reg.state == CBCE_S_DRAIN);

   // ****************************************************************
   // command screening
   // ****************************************************************
   // encrypted four-byte writes cannot be honoured, so refuse up front
   assign cmd_reject = !(i_cmd_code inside {[CBCE_CMD_AUTH:CBCE_CMD_COMB]})
                       || (i_cmd_p1 == 8'h00)
                       || ((i_cmd_code == CBCE_CMD_WRITE) && i_cmd_p2[CBCE_P2_LEN4_BIT]
                           && i_cmd_p2[CBCE_P2_ENC_BIT]);

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      logic [7:0]    b0;
      logic [4:0]    need;
      logic          len4;
      logic          adv;
      logic [31:0]   val;
      cbce_card_op_t p_op;
      logic [7:0]    p_addr;
      logic [7:0]    p_arg;
      logic          p_flag;
      logic          p_skip;
      logic          p_last;
      logic [127:0]  p_data;
      r_next = r_reg;
      b0     = (r_reg.idx == 5'h00) ? fifo_data[7:0] : r_reg.ent[0];
      len4   = r_reg.p2[CBCE_P2_LEN4_BIT];
      adv    = 1'b0;
      val    = {r_reg.ent[4], r_reg.ent[3], r_reg.ent[2], r_reg.ent[1]};
      p_op   = CBCE_OP_AUTH;
      p_addr = r_reg.ent[0];
      p_arg  = r_reg.ent[1];
      p_flag = 1'b0;
      p_skip = 1'b0;
      p_last = 1'b0;
      p_data = '0;
      need   = CBCE_NEED_PAIR;

      // entry length
      unique case (r_reg.cmd)
         CBCE_CMD_READ:   need = CBCE_NEED_READ;
         CBCE_CMD_WRITE:  need = len4 ? CBCE_NEED_W4 : CBCE_NEED_W16;
         CBCE_CMD_VWRITE: need = CBCE_NEED_VALUE;
         CBCE_CMD_INC:    need = CBCE_NEED_VALUE;
         CBCE_CMD_DEC:    need = CBCE_NEED_VALUE;
         CBCE_CMD_COMB:   need = (b0[CBCE_CF_NEW_BIT] && !b0[CBCE_CF_REUSE_BIT]) ? CBCE_NEED_KEY
                                                                            : CBCE_NEED_PAIR;
         default:         need = CBCE_NEED_PAIR;
      endcase

      // card operation plan for the current entry and step
      unique case (r_reg.cmd)
         CBCE_CMD_AUTH: begin
            p_flag = r_reg.p2[CBCE_P2_DIV_BIT];
         end
         CBCE_CMD_READ: begin
            p_op = CBCE_OP_READ;
         end
         CBCE_CMD_WRITE: begin
            p_op   = len4 ? CBCE_OP_WRITE4 : CBCE_OP_WRITE16;
            p_flag = !len4 && r_reg.auth_done;
            for (int i = 0; i < CBCE_BLOCK_BYTES; i++) begin
               if (!len4 || (i < CBCE_SHORT_BYTES)) begin
                  p_data[8*i +: 8] = r_reg.ent[i+1];
               end
            end
         end
         CBCE_CMD_VWRITE: begin
            p_op   = CBCE_OP_WRITE16;
            p_flag = r_reg.auth_done;
            p_data = {~r_reg.ent[5], r_reg.ent[5], ~r_reg.ent[5], r_reg.ent[5], val, ~val, val};
         end
         CBCE_CMD_INC, CBCE_CMD_DEC: begin
            p_last = 1'b1;
            if (!r_reg.step) begin
               p_op   = (r_reg.cmd == CBCE_CMD_INC) ? CBCE_OP_INC : CBCE_OP_DEC;
               p_data = {96'h0, r_reg.ent[5], r_reg.ent[4], r_reg.ent[3], r_reg.ent[2]};
            end else begin
               p_op   = CBCE_OP_TRANSFER;
               p_addr = r_reg.ent[1];
            end
         end
         CBCE_CMD_COPY: begin
            p_last = 1'b1;
            if (!r_reg.step) begin
               p_op = CBCE_OP_RESTORE;
            end else begin
               p_op   = CBCE_OP_TRANSFER;
               p_addr = r_reg.ent[1];
            end
         end
         CBCE_CMD_COMB: begin
            p_last = 1'b1;
            p_addr = r_reg.ent[1];
            p_arg  = r_reg.ent[0][CBCE_CF_REUSE_BIT] ? r_reg.key_ref : r_reg.ent[2];
            p_flag = r_reg.ent[0][CBCE_CF_DIV_BIT];
            if (!r_reg.step) begin
               p_skip = !r_reg.ent[0][CBCE_CF_NEW_BIT];
            end else begin
               p_op = CBCE_OP_READ;
            end
         end
         default: begin
         end
      endcase

      unique case (r_reg.state)
         CBCE_S_IDLE: begin
            if (i_cmd_valid) begin
               r_next.cmd       = i_cmd_code;
               r_next.count     = i_cmd_p1;
               r_next.p2        = i_cmd_p2;
               r_next.idx       = 5'h00;
               r_next.step      = 1'b0;
               r_next.seen_last = 1'b0;
               if (cmd_reject) begin
                  r_next.status = CBCE_ST_REJECT;
                  r_next.state  = CBCE_S_DRAIN;
               end else begin
                  r_next.status = CBCE_ST_OK;
                  r_next.state  = CBCE_S_FETCH;
               end
            end
         end
         CBCE_S_FETCH: begin
            if (fifo_valid) begin
               r_next.ent[r_reg.idx] = fifo_data[7:0];
               r_next.seen_last      = r_reg.seen_last | fifo_data[8];
               r_next.idx            = r_reg.idx + 5'h01;
               if ((r_reg.idx + 5'h01) == need) begin
                  r_next.step  = 1'b0;
                  r_next.state = CBCE_S_ISSUE;
               end else if (fifo_data[8]) begin
                  r_next.status = CBCE_ST_FORMAT;
                  r_next.state  = CBCE_S_DONE;
               end
            end
         end
         CBCE_S_ISSUE: begin
            if (p_skip) begin
               r_next.step = 1'b1;
            end else begin
               r_next.card_op    = p_op;
               r_next.card_addr  = p_addr;
               r_next.card_arg   = p_arg;
               r_next.card_flag  = p_flag;
               r_next.card_wdata = p_data;
               r_next.state      = CBCE_S_WAIT;
            end
         end
         CBCE_S_WAIT: begin
            if (i_card_ack) begin
               if (!i_card_ok) begin
                  r_next.status = CBCE_ST_CARD;
                  if (r_reg.card_op == CBCE_OP_AUTH) begin
                     r_next.auth_done = 1'b0;
                  end
                  r_next.state = r_reg.seen_last ? CBCE_S_DONE : CBCE_S_DRAIN;
               end else begin
                  if (r_reg.card_op == CBCE_OP_AUTH) begin
                     r_next.auth_done = 1'b1;
                     r_next.key_ref   = r_reg.card_arg;
                  end
                  if (r_reg.card_op == CBCE_OP_READ) begin
                     r_next.rsp_block = i_card_rdata;
                     r_next.state     = CBCE_S_RESP;
                  end else if (r_reg.step == p_last) begin
                     adv = 1'b1;
                  end else begin
                     r_next.step  = 1'b1;
                     r_next.state = CBCE_S_ISSUE;
                  end
               end
            end
         end
         CBCE_S_RESP: begin
            if (i_rsp_ready) begin
               adv = 1'b1;
            end
         end
         CBCE_S_DRAIN: begin
            // discard the rest of a refused or failed data field
            if (fifo_valid && fifo_data[8]) begin
               r_next.state = CBCE_S_DONE;
            end
         end
         CBCE_S_DONE: begin
            r_next.state = CBCE_S_IDLE;
         end
         default: begin
            r_next.state = CBCE_S_IDLE;
         end
      endcase

      // strictly one entry after another, in field order
      if (adv) begin
         r_next.count = r_reg.count - 8'h01;
         r_next.idx   = 5'h00;
         r_next.step  = 1'b0;
         if (r_reg.count == 8'h01) begin
            if (r_reg.seen_last) begin
               r_next.state = CBCE_S_DONE;
            end else begin
               r_next.status = CBCE_ST_FORMAT;
               r_next.state  = CBCE_S_DRAIN;
            end
         end else if (r_reg.seen_last) begin
            r_next.status = CBCE_ST_FORMAT;
            r_next.state  = CBCE_S_DONE;
         end else begin
            r_next.state = CBCE_S_FETCH;
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign o_cmd_ready  = (r_reg.state == CBCE_S_IDLE);
   assign o_rsp_valid  = (r_reg.state == CBCE_S_RESP);
   assign o_rsp_block  = r_reg.rsp_block;
   assign o_done       = (r_reg.state == CBCE_S_DONE);
   assign o_status     = r_reg.status;
   assign o_auth_state = r_reg.auth_done;
   assign o_card_req   = (r_reg.state == CBCE_S_WAIT);
   assign o_card_op    = r_reg.card_op;
   assign o_card_addr  = r_reg.card_addr;
   assign o_card_arg   = r_reg.card_arg;
   assign o_card_flag  = r_reg.card_flag;
   assign o_card_wdata = r_reg.card_wdata;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);

   sequence s_arith_ok;
      i_card_ack && i_card_ok && (r_reg.card_op inside {CBCE_OP_INC, CBCE_OP_DEC});
   endsequence

   sequence s_transfer_req;
      o_card_req && (r_reg.card_op == CBCE_OP_TRANSFER) && (o_card_addr == r_reg.ent[1]);
   endsequence

   sequence s_comb_auth_ok;
      (r_reg.cmd == CBCE_CMD_COMB) && i_card_ack && i_card_ok && (r_reg.card_op == CBCE_OP_AUTH);
   endsequence

   sequence s_read_req;
      o_card_req && (r_reg.card_op == CBCE_OP_READ);
   endsequence

   AST_AUTH_KEY: assert property (
      (o_card_req && (r_reg.cmd == CBCE_CMD_AUTH)) |-> (o_card_op == 3'(CBCE_OP_AUTH)) && (o_card_arg == r_reg.ent[1]))
      else $error("auth key reference not taken from data field");

   AST_AUTH_DIV: assert property (
      (o_card_req && (r_reg.cmd == CBCE_CMD_AUTH)) |-> (o_card_flag == r_reg.p2[CBCE_P2_DIV_BIT]))
      else $error("diversify flag does not follow request");

   AST_READ_RETURN: assert property (
      (i_card_ack && i_card_ok && (r_reg.card_op == CBCE_OP_READ) && o_card_req)
      |=> o_rsp_valid && (o_rsp_block == $past(i_card_rdata)))
      else $error("read block not returned to host");

   AST_WRITE_LEN: assert property (
      (o_card_req && (r_reg.cmd == CBCE_CMD_WRITE))
      |-> ((o_card_op == 3'(CBCE_OP_WRITE4)) == r_reg.p2[CBCE_P2_LEN4_BIT]))
      else $error("write length does not follow parameter bit");

   AST_WRITE16_ENC: assert property (
      (o_card_req && (r_reg.card_op == CBCE_OP_WRITE16)) |-> (o_card_flag == o_auth_state))
      else $error("sixteen-byte encryption does not follow auth state");

   AST_WRITE4_PLAIN: assert property (
      (o_card_req && (r_reg.card_op == CBCE_OP_WRITE4)) |-> !o_card_flag)
      else $error("four-byte write sent encrypted");

   AST_VALUE_FMT: assert property (
      (o_card_req && (r_reg.cmd == CBCE_CMD_VWRITE))
      |-> (o_card_wdata[63:32] == ~o_card_wdata[31:0]) && (o_card_wdata[95:64] == o_card_wdata[31:0])
          && (o_card_wdata[111:104] == ~o_card_wdata[103:96]) && (o_card_wdata[103:96] == r_reg.ent[5]))
      else $error("value block format wrong");

   AST_ARITH_TRANSFER: assert property (
      s_arith_ok |-> ##[1:3] s_transfer_req)
      else $error("no transfer after value arithmetic");

   AST_COMB_READ: assert property (
      s_comb_auth_ok |-> ##[1:3] s_read_req)
      else $error("no read after combined authentication");

   AST_REJECT_QUIET: assert property (
      (o_cmd_ready && i_cmd_valid && cmd_reject) |=> (!o_card_req until_with o_done))
      else $error("card touched by rejected command");

endmodule // cbce_engine

// File: tb/cbce_card_model.sv
`timescale 1ns/1ps
// ****************************************************************
// card behind the reader
// ****************************************************************
module cbce_card_model (
   // clock
   input  wire logic         i_clock,
   // operation from the engine, latency from the testbench
   input  wire logic         i_req,
   input  wire logic [2:0]   i_op,
   input  wire logic [7:0]   i_addr,
   input  wire logic [127:0] i_wdata,
   input  wire logic [1:0]   i_delay,
   // answer
   output logic              o_ack,
   output logic              o_ok,
   output logic      [127:0] o_rdata
);
   logic [127:0] mem [256];
   logic [1:0]   wait_reg;
   initial begin
      o_ack = 1'b0;
      o_ok = 1'b0;
      o_rdata = '0;
      wait_reg = 2'h0;
      for (int a = 0; a < 256; a++) mem[a] = {16{a[7:0] ^ 8'h5a}};
   end
   // address ee refuses every operation, so failures can be provoked
   always @(posedge i_clock) begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata; // stale read data never looks valid
      if (!i_req) wait_reg <= i_delay;
      else if (!o_ack && wait_reg != 2'h0) wait_reg <= wait_reg - 2'h1;
      else if (!o_ack) begin
         o_ack <= 1'b1;
         o_ok <= (i_addr != 8'hee);
         o_rdata <= mem[i_addr];
         if (i_op == 3'h2 || i_op == 3'h3) mem[i_addr] <= i_wdata;
      end
   end
endmodule // cbce_card_model

// File: tb/card_block_command_engine_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin bad_count++; \
   $display("CHECK FAILED %s expected %h seen %h", n, e, s); end end
module card_block_command_engine_tb;
   import cbce_pkg::*;
   logic clk, rst_n, cv, cr, dv, dl, dr, rv, rr, done, auth, req, flag, ack, ok;
   logic [3:0] code;
   logic [7:0] p1, p2, db, addr, arg;
   logic [1:0] st, dly;
   logic [2:0] op;
   logic [127:0] rb, wd, rd, last_wd;
   logic [63:0] expq [$];
   logic [31:0] v;
   logic [7:0] lst [$];
   int bad_count = 0, total_checks = 0, seed = 29;
   cbce_engine dut (.i_clock(clk), .i_rst_n(rst_n), .i_cmd_valid(cv), .i_cmd_code(code), .i_cmd_p1(p1),
      .i_cmd_p2(p2), .o_cmd_ready(cr), .i_data_valid(dv), .i_data_byte(db), .i_data_last(dl),
      .o_data_ready(dr), .o_rsp_valid(rv), .o_rsp_block(rb), .i_rsp_ready(rr), .o_done(done), .o_status(st),
      .o_auth_state(auth), .o_card_req(req), .o_card_op(op), .o_card_addr(addr), .o_card_arg(arg),
      .o_card_flag(flag), .o_card_wdata(wd), .i_card_ack(ack), .i_card_ok(ok), .i_card_rdata(rd));
   cbce_card_model card (.i_clock(clk), .i_req(req), .i_op(op), .i_addr(addr), .i_wdata(wd),
      .i_delay(dly), .o_ack(ack), .o_ok(ok), .o_rdata(rd));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   function automatic logic [63:0] ev(logic [3:0] k, logic [2:0] o, logic [7:0] a, ar, f, logic [31:0] d);
      return {k, 1'b0, o, a, ar, f, d};
   endfunction
   function automatic void ex(logic [3:0] k, logic [2:0] o, logic [7:0] a, ar, f, logic [31:0] d);
      expq.push_back(ev(k, o, a, ar, f, d));
   endfunction
   task automatic check(logic [63:0] s);
      logic [63:0] e;
      e = expq.size() ? expq.pop_front() : '1;
      `CHK("event", e, s)
   endtask
   // ****************************************************************
   // monitor: card operations, returned blocks, status
   // ****************************************************************
   always @(posedge clk) if (rst_n) begin
      if (req && ack) begin
         last_wd = wd;
         check(ev(4'h1, op, addr, op == 3'h0 ? arg : 8'h0, op inside {0, 2, 3} ? 8'(flag) : 8'h0,
            op inside {2, 3, 4, 5} ? wd[31:0] : 32'h0));
      end
      if (rv && rr) check(ev(4'h2, 3'h0, 8'h0, 8'h0, 8'h0, rb[31:0]));
      if (done) check(ev(4'h3, 3'h0, 8'h0, 8'h0, 8'h0, 32'(st)));
   end
   // random host stalls and card latency
   always @(posedge clk) begin
      #1 rr = 1'($random(seed));
      dly = 2'($random(seed));
   end
   task automatic cmd(logic [3:0] c, logic [7:0] n, q, logic [7:0] b[$], logic [1:0] s);
      ex(4'h3, 3'h0, 8'h0, 8'h0, 8'h0, 32'(s));
      cv = 1'b1;
      code = c;
      p1 = n;
      p2 = q;
      @(posedge clk iff cr);
      #1 cv = 1'b0;
      foreach (b[i]) begin
         dv = 1'b1;
         db = b[i];
         dl = (i == b.size() - 1);
         @(posedge clk iff dr);
         #1;
      end
      dv = 1'b0;
      dl = 1'b0;
      @(posedge clk iff done);
      #1;
   endtask
   task automatic wr(int len, logic [7:0] q, logic f);
      logic [7:0] b[$];
      logic [127:0] w;
      int base;
      for (int e = 0; e < 2; e++) begin
         b.push_back(8'h10 + 8'(e));
         base = b.size();
         w = '0;
         for (int k = 0; k < len; k++) begin
            b.push_back(8'($random(seed)));
            w[8*k +: 8] = b[base+k];
         end
         ex(4'h1, len == 16 ? 3'h2 : 3'h3, 8'h10 + 8'(e), 8'h0, f, {b[base+3], b[base+2], b[base+1], b[base]});
      end
      cmd(CBCE_CMD_WRITE, 8'h2, q, b, CBCE_ST_OK);
      `CHK("wdata", w, last_wd)
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      end_of_test();
   end
   initial begin
      {cv, dv, dl, db, code, p1, p2, rst_n} = '0;
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      ex(4'h1, 3'h0, 8'h04, 8'h05, 8'h1, 32'h0);
      cmd(CBCE_CMD_AUTH, 8'h1, 8'h1, '{8'h04, 8'h05}, CBCE_ST_OK);
      `CHK("auth", 1'b1, auth)
      lst = '{8'h09, 8'h02, 8'h07};
      foreach (lst[i]) begin
         ex(4'h1, 3'h1, lst[i], 8'h0, 8'h0, 32'h0);
         ex(4'h2, 3'h0, 8'h0, 8'h0, 8'h0, {4{lst[i] ^ 8'h5a}});
      end
      cmd(CBCE_CMD_READ, 8'h3, 8'h0, lst, CBCE_ST_OK);
      wr(16, 8'h0, 1'b1);
      wr(4, 8'h1, 1'b0);
      cmd(CBCE_CMD_WRITE, 8'h1, 8'h3, '{8'h20, 8'h1, 8'h2, 8'h3, 8'h4}, CBCE_ST_REJECT);
      cmd(4'hf, 8'h1, 8'h0, '{8'h20}, CBCE_ST_REJECT);
      cmd(CBCE_CMD_READ, 8'h0, 8'h0, '{8'h20}, CBCE_ST_REJECT);
      v = $random(seed);
      ex(4'h1, 3'h2, 8'h30, 8'h0, 8'h1, v);
      cmd(CBCE_CMD_VWRITE, 8'h1, 8'h0, '{8'h30, v[7:0], v[15:8], v[23:16], v[31:24], 8'h31}, CBCE_ST_OK);
      `CHK("value", {8'hce, 8'h31, 8'hce, 8'h31, v, ~v, v}, last_wd)
      for (int c = 5; c < 8; c++) begin
         v = (c == 7) ? 32'h0 : $random(seed);
         ex(4'h1, 3'(c - 1), 8'h40, 8'h0, 8'h0, v);
         ex(4'h1, 3'h7, 8'h50, 8'h0, 8'h0, 32'h0);
         ex(4'h1, 3'(c - 1), 8'h41, 8'h0, 8'h0, v);
         ex(4'h1, 3'h7, 8'h51, 8'h0, 8'h0, 32'h0);
         if (c == 7) cmd(4'(c), 8'h2, 8'h0, '{8'h40, 8'h50, 8'h41, 8'h51}, CBCE_ST_OK);
         else cmd(4'(c), 8'h2, 8'h0, '{8'h40, 8'h50, v[7:0], v[15:8], v[23:16], v[31:24], 8'h41, 8'h51,
            v[7:0], v[15:8], v[23:16], v[31:24]}, CBCE_ST_OK);
      end
      ex(4'h1, 3'h0, 8'h60, 8'h03, 8'h1, 32'h0);
      lst = '{8'h60, 8'h61, 8'h62};
      foreach (lst[i]) begin
         if (i == 2) ex(4'h1, 3'h0, 8'h62, 8'h03, 8'h0, 32'h0);
         ex(4'h1, 3'h1, lst[i], 8'h0, 8'h0, 32'h0);
         ex(4'h2, 3'h0, 8'h0, 8'h0, 8'h0, {4{lst[i] ^ 8'h5a}});
      end
      cmd(CBCE_CMD_COMB, 8'h3, 8'h0, '{8'h03, 8'h60, 8'h03, 8'h00, 8'h61, 8'h05, 8'h62}, CBCE_ST_OK);
      ex(4'h1, 3'h0, 8'hee, 8'h02, 8'h0, 32'h0);
      cmd(CBCE_CMD_AUTH, 8'h1, 8'h0, '{8'hee, 8'h02}, CBCE_ST_CARD);
      `CHK("auth", 1'b0, auth)
      wr(16, 8'h0, 1'b0);
      `CHK("left", 32'h0, 32'(expq.size()))
      end_of_test();
   end
endmodule // card_block_command_engine_tb
